// >>> dv/loader_props.sv
// Checker for the divider loader outputs
`default_nettype none
module loader_props
  import synth_loader_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic loadEnable,
  input wire logic strapMode,
  input wire logic [SEL_W-1:0] channelSelectPins,
  input wire logic [REF_W-1:0] referenceRatioBits,
  input wire logic [15:0] referenceTotal,
  input wire logic [SWALLOW_W-1:0] swallowCount,
  input wire logic [PULSE_W-1:0] pulseCount,
  input wire logic referenceIs25k,
  input wire logic [GROUP_W-1:0] channelGroup
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence strapHeld;
    (strapMode && $stable(channelSelectPins))[*6];
  endsequence
  reset_values_a: assert property ($rose(rst_b) |-> referenceRatioBits == REF_RESET &&
    {pulseCount, swallowCount} == CHAN_RESET) else $error("reset values wrong");
  ref_double_a: assert property (referenceTotal == {5'h00, referenceRatioBits, 1'b0})
    else $error("reference total not twice ratio");
  strap_ref_a: assert property (strapMode[*6] |-> referenceTotal == REF_FIXED_STRAP)
    else $error("strap reference not fixed");
  strap_group_a: assert property (strapHeld |-> channelGroup == channelSelectPins[5:4])
    else $error("group mismatch");
  strap_rate_a: assert property (strapHeld |-> referenceIs25k == !channelSelectPins[5])
    else $error("rate flag mismatch");
  strap_word_a: assert property (strapHeld |-> swallowCount == 4'h0 &&
    pulseCount == PULSE_W'(channelSelectPins) + 12'h003) else $error("strap word wrong");
  serial_flags_a: assert property ((!strapMode)[*6] |-> channelGroup == 2'h0 && !referenceIs25k)
    else $error("flags set in serial mode");
  divider_hold_a: assert property ((!strapMode && !loadEnable)[*8] |-> $stable(pulseCount) &&
    $stable(swallowCount) && $stable(referenceRatioBits)) else $error("divider changed");
  cover property ($rose(loadEnable));
  cover property (strapHeld);
  cover property ($changed(pulseCount));
endmodule
`default_nettype wire

// >>> dv/mcu_port_model.sv
// Behavioural controller driving the three-wire port
`default_nettype none
module mcu_port_model (
  input wire logic clock,
  output logic serialClk,
  output logic serialData,
  output logic loadEnable
);
  initial begin
    serialClk = 0;
    serialData = 0;
    loadEnable = 0;
  end
  // Bit n-1 goes last, so the group code closes the word
  task sendWord(input logic [17:0] w, input int n);
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge clock);
      #1 serialClk = 0;
      serialData = w[i];
      repeat (4) @(posedge clock);
      #1 serialClk = 1;
    end
    repeat (4) @(posedge clock);
    #1 serialClk = 0;
    serialData = ~serialData; // Data line inverted, so the last bit's value is not kept
    repeat (4) @(posedge clock);
    #1 loadEnable = 1;
    repeat (8) @(posedge clock);
    #1 loadEnable = 0;
    repeat (8) @(posedge clock);
    #1;
  endtask
endmodule
`default_nettype wire

// >>> dv/tb.sv
// Self-checking bench for the divider loader
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import synth_loader_pkg::*;
  logic clock = 0, rst_b = 0, strapMode = 0, is25k;
  logic [SEL_W-1:0] sel = '0;
  wire serialClk, serialData, loadEnable;
  logic [REF_W-1:0] refBits;
  logic [15:0] refTot;
  logic [3:0] a;
  logic [11:0] b;
  logic [1:0] grp;
  logic [5:0] tbl[4] = '{6'h00, 6'h14, 6'h21, 6'h3C};
  int n_mismatch = 0, total_checks = 0, cyc = 0;
  always #50 clock = ~clock;
  mcu_port_model mcu_port_model_inst (.clock(clock), .serialClk(serialClk),
    .serialData(serialData), .loadEnable(loadEnable));
  synth_divider_config_loader synth_divider_config_loader_inst (.clock(clock), .rst_b(rst_b),
    .serialClk(serialClk), .serialData(serialData), .loadEnable(loadEnable),
    .strapMode(strapMode), .channelSelectPins(sel), .referenceRatioBits(refBits),
    .referenceTotal(refTot), .swallowCount(a), .pulseCount(b), .referenceIs25k(is25k),
    .channelGroup(grp));
  task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task ref_chk(input logic [9:0] r);
    chk("ratio", 16'(r), 16'(refBits));
    chk("total", 16'(16'(r) * 2), refTot);
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      stop_test;
    end
  end
  initial begin
    repeat (10) @(posedge clock);
    #1 rst_b = 1;
    repeat (3) @(posedge clock);
    #1;
    ref_chk(10'h003);
    chk("chan", CHAN_RESET, {b, a});
    $display("reset tests done");
    mcu_port_model_inst.sendWord(18'h00D90, 12);
    ref_chk(10'h190);
    mcu_port_model_inst.sendWord(18'h21FC5, 18);
    chk("chan", 16'h1FC5, {b, a});
    mcu_port_model_inst.sendWord(18'h31234, 18);
    mcu_port_model_inst.sendWord(18'h01234, 18);
    mcu_port_model_inst.sendWord(18'h00555, 12);
    mcu_port_model_inst.sendWord(18'h00ABC, 12);
    chk("chan", 16'h1FC5, {b, a});
    ref_chk(10'h190);
    mcu_port_model_inst.sendWord(18'h00FFF, 12);
    mcu_port_model_inst.sendWord(18'h2FFFF, 18);
    ref_chk(10'h3FF);
    chk("chan", 16'hFFFF, {b, a});
    $display("serial tests done");
    strapMode = 1;
    foreach (tbl[i]) begin
      @(posedge clock);
      #1 sel = tbl[i];
      repeat (8) @(posedge clock);
      #1;
      chk("total", REF_FIXED_STRAP, refTot);
      chk("ratio", 16'(REF_FIXED_PROG), 16'(refBits));
      chk("group", 16'(tbl[i][5:4]), 16'(grp));
      chk("rate", 16'(!tbl[i][5]), 16'(is25k));
      chk("word", 16'(16'(tbl[i]) * 16 + 16'h0030), {b, a});
    end
    $display("strap tests done");
    stop_test;
  end
endmodule
bind synth_divider_config_loader loader_props loader_props_inst (.clock(clock),
  .rst_b(rst_b), .loadEnable(loadEnable), .strapMode(strapMode),
  .channelSelectPins(channelSelectPins), .referenceRatioBits(referenceRatioBits),
  .referenceTotal(referenceTotal), .swallowCount(swallowCount), .pulseCount(pulseCount),
  .referenceIs25k(referenceIs25k), .channelGroup(channelGroup));
`default_nettype wire

// >>> hdl/synth_divider_config_loader.sv
// Serial and pin-strapped loader for the synthesizer divider settings
// Notes on behaviour
// - Serial data is shifted in on every rising edge of the serial clock.
// - The last two shifted bits are decoded as a group code naming the target divider.
// - A high level on load enable moves the shifted word into the selected divider.
// - While load enable is high the shift contents are delivered to the selected divider.
// - The 6-bit channel select is decoded into 64 one-hot lines by row and column.
// - Each decoded line selects one stored 18-bit division word for the counters.
// - A channel select pin reads low when floating and high when tied to supply.
// - The 64 channels form four groups chosen by the select value.
// - Groups one and two assume a 25 kHz reference, groups three and four 5 kHz.
// - The reference word is a 10-bit ratio followed by group code bits both one.
// - The channel word is 4-bit A, 12-bit B, group code second bit zero, last bit one.
// - In the strapped variant the reference ratio is fixed at 400, a total of 800.
`default_nettype none
module synth_divider_config_loader (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Three-wire serial port
  input wire logic serialClk,
  input wire logic serialData,
  input wire logic loadEnable,
  // Variant select: high selects pin-strapped mode
  input wire logic strapMode,
  // Channel select pins
  input wire logic [synth_loader_pkg::SEL_W-1:0] channelSelectPins,
  // Divider outputs
  output logic [synth_loader_pkg::REF_W-1:0] referenceRatioBits,
  output logic [15:0] referenceTotal,
  output logic [synth_loader_pkg::SWALLOW_W-1:0] swallowCount,
  output logic [synth_loader_pkg::PULSE_W-1:0] pulseCount,
  output logic referenceIs25k,
  output logic [synth_loader_pkg::GROUP_W-1:0] channelGroup
);
  import synth_loader_pkg::*;

  // Two-flop synchronisers; first stage read only by second
  logic [2:0] syncA_reg;
  logic [2:0] syncB_reg;
  logic [SEL_W-1:0] selA_reg;
  logic [SEL_W-1:0] selB_reg;
  logic modeA_reg;
  logic modeB_reg;
  logic clkPrev_reg;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      syncA_reg <= 3'h0;
      syncB_reg <= 3'h0;
      selA_reg <= 6'h00;
      selB_reg <= 6'h00;
      modeA_reg <= 1'b0;
      modeB_reg <= 1'b0;
      clkPrev_reg <= 1'b0;
    end else begin
      syncA_reg <= {loadEnable, serialData, serialClk};
      syncB_reg <= syncA_reg;
      selA_reg <= channelSelectPins;
      selB_reg <= selA_reg;
      modeA_reg <= strapMode;
      modeB_reg <= modeA_reg;
      clkPrev_reg <= syncB_reg[0];
    end
  end

  logic clkRise;
  assign clkRise = syncB_reg[0] & ~clkPrev_reg;

  // Shift register; newest bit enters at the top so the LSB ends lowest
  logic [SHIFT_W-1:0] shift_reg;
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      shift_reg <= 18'h0_0000;
    end else if (clkRise) begin
      shift_reg <= {syncB_reg[1], shift_reg[SHIFT_W-1:1]};
    end
  end

  // Kept until the next serial clock so the count restarts at 1 on the first bit after a load, however long
  logic wordDone_reg;
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      wordDone_reg <= 1'b0;
    end else if (syncB_reg[2]) begin
      wordDone_reg <= 1'b1;
    end else if (clkRise) begin
      wordDone_reg <= 1'b0;
    end
  end

  // Bits since the last load; saturates so a long burst never aliases
  logic [5:0] bitCount_reg;
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      bitCount_reg <= 6'h00;
    end else if (clkRise) begin
      if (wordDone_reg) begin
        bitCount_reg <= 6'h01;
      end else if (bitCount_reg < 6'h3f) begin
        bitCount_reg <= bitCount_reg + 6'h01;
      end
    end
  end

  // Short words sit high in the register; realign by length
  logic [SHIFT_W-1:0] word;
  assign word = shift_reg >> (SHIFT_W - REF_WORD_LEN);
  logic [1:0] refCode;
  logic [1:0] chanCode;
  assign refCode = word[REF_GC_POS +: 2];
  assign chanCode = shift_reg[CHAN_GC_POS +: 2];

  // Length and code must both match, else the word is dropped
  logic refWord;
  logic chanWord;
  assign refWord = (bitCount_reg == 6'(REF_WORD_LEN)) && (refCode == GC_REF);
  assign chanWord = (bitCount_reg == 6'(CHAN_WORD_LEN)) && (chanCode == GC_CHAN);

  // Serial mode divider registers, reloaded while load enable stays high
  logic [REF_W-1:0] progRef_reg;
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      progRef_reg <= REF_RESET;
    end else if (syncB_reg[2] && refWord) begin
      progRef_reg <= word[REF_W-1:0];
    end
  end

  logic [CHAN_W-1:0] progChan_reg;
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      progChan_reg <= CHAN_RESET;
    end else if (syncB_reg[2] && chanWord) begin
      progChan_reg <= shift_reg[CHAN_W-1:0];
    end
  end

  // Row/column decode of the strap value into one-hot lines
  function automatic logic [NUM_CHAN-1:0] decodeSel(input logic [SEL_W-1:0] sel);
    logic [7:0] row;
    logic [7:0] col;
    logic [NUM_CHAN-1:0] lines;
    row = 8'h01 << sel[SEL_W-1:ROW_W];
    col = 8'h01 << sel[ROW_W-1:0];
    for (int r = 0; r < 8; r++) begin
      for (int c = 0; c < 8; c++) begin
        lines[r*8+c] = row[r] & col[c];
      end
    end
    return lines;
  endfunction

  // Stored words: fixed table, B=3+index, A=0
  function automatic logic [SHIFT_W-1:0] romWord(input logic [NUM_CHAN-1:0] lines);
    logic [SHIFT_W-1:0] w;
    w = 18'h0_0000;
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (lines[i]) begin
        w = {GC_CHAN, 6'h0, 6'(i), 4'h0} + 18'h0_0030;
      end
    end
    return w;
  endfunction

  logic [NUM_CHAN-1:0] lines;
  logic [SHIFT_W-1:0] romSel;
  assign lines = decodeSel(selB_reg);
  assign romSel = romWord(lines);

  // Fixed halving stage ahead of the programmable ratio
  function automatic logic [15:0] refTotalOf(input logic [REF_W-1:0] ratio);
    return {5'h00, ratio, 1'b0};
  endfunction

  // Output registers, one per divider field
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      referenceRatioBits <= REF_RESET;
    end else if (modeB_reg) begin
      referenceRatioBits <= REF_FIXED_PROG;
    end else begin
      referenceRatioBits <= progRef_reg;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      referenceTotal <= refTotalOf(REF_RESET);
    end else if (modeB_reg) begin
      referenceTotal <= REF_FIXED_STRAP;
    end else begin
      referenceTotal <= refTotalOf(progRef_reg);
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      swallowCount <= CHAN_RESET[SWALLOW_POS +: SWALLOW_W];
    end else if (modeB_reg) begin
      swallowCount <= romSel[SWALLOW_POS +: SWALLOW_W];
    end else begin
      swallowCount <= progChan_reg[SWALLOW_POS +: SWALLOW_W];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      pulseCount <= CHAN_RESET[PULSE_POS +: PULSE_W];
    end else if (modeB_reg) begin
      pulseCount <= romSel[PULSE_POS +: PULSE_W];
    end else begin
      pulseCount <= progChan_reg[PULSE_POS +: PULSE_W];
    end
  end

  // Group and rate flags only mean something in the strapped variant
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      channelGroup <= 2'h0;
    end else if (modeB_reg) begin
      channelGroup <= selB_reg[SEL_W-1 -: GROUP_W];
    end else begin
      channelGroup <= 2'h0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      referenceIs25k <= 1'b0;
    end else if (modeB_reg) begin
      referenceIs25k <= ~selB_reg[SEL_W-1];
    end else begin
      referenceIs25k <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> hdl/synth_loader_pkg.sv
// Constants shared by the divider configuration loader
`default_nettype none
package synth_loader_pkg;
  localparam int SHIFT_W = 18;
  localparam int REF_W = 10;
  localparam int SWALLOW_W = 4;
  localparam int PULSE_W = 12;
  localparam int CHAN_W = SWALLOW_W + PULSE_W;
  localparam int SEL_W = 6;
  localparam int NUM_CHAN = 64;
  localparam int GROUP_W = 2;
  // Serial word lengths in bits
  localparam int REF_WORD_LEN = 12;
  localparam int CHAN_WORD_LEN = 18;
  // Group code values (last bit, second-last bit)
  localparam logic [1:0] GC_REF = 2'h3;
  localparam logic [1:0] GC_CHAN = 2'h2;
  // Reference word: ratio in bits 9:0, group code in bits 11:10
  localparam int REF_GC_POS = 10;
  // Channel word: A in 3:0, B in 15:4, group code in 17:16
  localparam int SWALLOW_POS = 0;
  localparam int PULSE_POS = 4;
  localparam int CHAN_GC_POS = 16;
  localparam logic [9:0] REF_RESET = 10'h003;
  localparam logic [15:0] CHAN_RESET = 16'h0030;
  localparam logic [15:0] REF_FIXED_STRAP = 16'h0320;
  localparam logic [9:0] REF_FIXED_PROG = 10'h190;
  localparam int ROW_W = 3;
endpackage
`default_nettype wire
